// *** include/sdlt_cfg.svh ***
// Constants and timing of the serial read latency table block
`ifndef SDLT_CFG_SVH
`define SDLT_CFG_SVH
`define SDLT_Q_ID        8'h90
`define SDLT_Q_LEN       8'h56
`define SDLT_Q_ROWS      8'h06
`define SDLT_Q_ROWLEN    7'h0E
`define SDLT_Q_ASC_F     8'h46
`define SDLT_Q_ASC_C     8'h43
`define SDLT_Q_OFF_ID    7'h00
`define SDLT_Q_OFF_LEN   7'h01
`define SDLT_Q_OFF_ROWS  7'h02
`define SDLT_Q_OFF_RLEN  7'h03
`define SDLT_Q_OFF_F     7'h04
`define SDLT_Q_OFF_OPC   7'h06
`define SDLT_Q_OFF_BODY  7'h12
`define SDLT_Q_OFF_ROW4  7'h2E
`define SDLT_Q_OFF_LAST  7'h57
`define SDLT_Q_TOP_ROW   7'h04
`define SDLT_OPC_RD3     8'h03
`define SDLT_OPC_RD4     8'h13
`define SDLT_OPC_FST3    8'h0B
`define SDLT_OPC_FST4    8'h0C
`define SDLT_OPC_DO3     8'h3B
`define SDLT_OPC_DO4     8'h3C
`define SDLT_OPC_QO3     8'h6B
`define SDLT_OPC_QO4     8'h6C
`define SDLT_OPC_DIO3    8'hBB
`define SDLT_OPC_DIO4    8'hBC
`define SDLT_OPC_QIO3    8'hEB
`define SDLT_OPC_QIO4    8'hEC
`define SDLT_F50         8'h32
`define SDLT_F80         8'h50
`define SDLT_F90         8'h5A
`define SDLT_F104        8'h68
`define SDLT_F133        8'h85
`define SDLT_LC_50       2'h3
`define SDLT_LC_80       2'h0
`define SDLT_LC_90       2'h1
`define SDLT_LC_104      2'h2
`define SDLT_NONE        8'h00
`define SDLT_NOSUP       8'hFF
`define SDLT_MODE_DIO    8'h04
`define SDLT_MODE_QIO    8'h02
`define SDLT_LAT_SLOW    8'h08
`define SDLT_LAT_DIO_90  8'h01
`define SDLT_LAT_DIO_104 8'h02
`define SDLT_LAT_QIO_50  8'h01
`define SDLT_LAT_QIO_80  8'h04
`define SDLT_LAT_QIO_104 8'h05
`define SDLT_ADDR3       6'h18
`define SDLT_ADDR4       6'h20
`endif

// *** include/sdlt_pkg.sv ***
// Types shared by the read latency table block
package sdlt_pkg;
   typedef enum logic [2:0] {CL_READ = 3'h0, CL_FAST = 3'h1,
      CL_DOUT = 3'h2, CL_QOUT = 3'h3, CL_DIO = 3'h4,
      CL_QIO = 3'h5} sdlt_cls_t;
   typedef enum logic [2:0] {ST_IDLE = 3'h0, ST_OPC = 3'h1,
      ST_ADDR = 3'h3, ST_DUMMY = 3'h2, ST_DATA = 3'h6,
      ST_IGN = 3'h7} sdlt_st_t;
   typedef struct packed {
      logic      ok;
      logic      four;
      sdlt_cls_t cls;
   } sdlt_dec_t;
   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] lat;
   } sdlt_cyc_t;
endpackage : sdlt_pkg

// *** include/sdlt_strm_if.sv ***
// Valid/ready byte stream between buffer and serialiser
`timescale 1ns/10ps
interface sdlt_strm_if #(parameter int W = 8) ();
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : sdlt_strm_if

// *** src/sdlt_buf.sv ***
// Small valid/ready buffer for read data bytes
`timescale 1ns/10ps
module sdlt_buf #(
   parameter int W     = 8,
   parameter int DEPTH = 2
) (
   input  wire logic         clock,
   input  wire logic         rstn,
   input  wire logic         flush,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   sdlt_strm_if.src          out
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] PLAST = PW'(DEPTH - 1);
   localparam logic [CW-1:0] CFULL = CW'(DEPTH);

   logic [W-1:0]  mem [DEPTH];
   logic [PW-1:0] wp;
   logic [PW-1:0] rp;
   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;
   logic          push;
   logic          pop;

   assign push     = in_valid && in_ready;
   assign pop      = out.valid && out.ready;
   assign out.data = mem[rp];

   always_comb
   begin
      next_cnt = cnt;
      if (push && !pop)
         next_cnt = cnt + CW'(1);
      else if (pop && !push)
         next_cnt = cnt - CW'(1);
   end

   // Flags are registered so ready and valid never ripple
   always_ff @(posedge clock)
      if (!rstn || flush)
      begin
         cnt       <= '0;
         wp        <= '0;
         rp        <= '0;
         in_ready  <= 1'b1;
         out.valid <= 1'b0;
      end
      else
      begin
         cnt       <= next_cnt;
         in_ready  <= next_cnt != CFULL;
         out.valid <= next_cnt != '0;
         if (push)
            wp <= (wp == PLAST) ? '0 : wp + PW'(1);
         if (pop)
            rp <= (rp == PLAST) ? '0 : rp + PW'(1);
      end

   always_ff @(posedge clock)
      if (push)
         mem[wp] <= in_data;

   AST_BUF_NO_OVERFLOW: assert property (@(posedge clock)
      disable iff (!rstn) cnt == CFULL |-> !in_ready)
      else $error("buffer full but ready high");
endmodule : sdlt_buf

// *** src/sdlt_top.sv ***
// Serial read decode, latency selection and query parameter
`timescale 1ns/10ps
`include "sdlt_cfg.svh"
module sdlt_top
   import sdlt_pkg::*;
#(
   parameter int BUF_DEPTH = 2
) (
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic        sck,
   input  wire logic        cs_n,
   input  wire logic [3:0]  io_in,
   output logic      [3:0]  io_out,
   output logic      [3:0]  io_oe,
   input  wire logic [1:0]  latency_code,
   output logic             rd_start,
   output logic      [31:0] rd_addr,
   output logic      [2:0]  rd_cls,
   output logic             rd_four,
   output logic             cmd_reject,
   input  wire logic        in_valid,
   input  wire logic [7:0]  in_data,
   output logic             in_ready,
   output logic             underrun,
   input  wire logic [6:0]  qry_addr,
   output logic      [7:0]  qry_data
);
   logic [2:0]  sck_p;
   logic [1:0]  cs_p;
   logic [3:0]  io_p0;
   logic [3:0]  io_s;
   logic        cs_s;
   logic        cs_d;
   logic        flush_q;
   logic        sck_rise;
   logic        sck_fall;
   sdlt_st_t    st;
   logic [2:0]  bit_cnt;
   logic [7:0]  opc;
   logic [7:0]  next_opc;
   sdlt_dec_t   dec;
   sdlt_cyc_t   cyc_new;
   sdlt_cyc_t   cyc_q;
   logic        accept;
   sdlt_cls_t   cls;
   logic        four;
   logic [1:0]  lc_q;
   logic [5:0]  addr_left;
   logic [5:0]  aw;
   logic [31:0] addr;
   logic [31:0] next_addr;
   logic [4:0]  dum_cnt;
   logic [4:0]  dum_tot;
   logic        opc_done;
   logic        addr_done;
   logic [2:0]  ow;
   logic [3:0]  bl;
   logic [7:0]  sh;
   logic [7:0]  cur;
   logic [3:0]  next_io;
   logic        need;

   sdlt_strm_if #(.W(8)) drain ();

   function automatic logic [7:0] opcode_of(input sdlt_cls_t c,
                                            input logic four_b);
      case (c)
         CL_READ: return four_b ? `SDLT_OPC_RD4 : `SDLT_OPC_RD3;
         CL_FAST: return four_b ? `SDLT_OPC_FST4 : `SDLT_OPC_FST3;
         CL_DOUT: return four_b ? `SDLT_OPC_DO4 : `SDLT_OPC_DO3;
         CL_QOUT: return four_b ? `SDLT_OPC_QO4 : `SDLT_OPC_QO3;
         CL_DIO:  return four_b ? `SDLT_OPC_DIO4 : `SDLT_OPC_DIO3;
         default: return four_b ? `SDLT_OPC_QIO4 : `SDLT_OPC_QIO3;
      endcase
   endfunction : opcode_of

   function automatic sdlt_dec_t decode(input logic [7:0] op);
      sdlt_dec_t d;
      d = '{ok: 1'b0, four: 1'b0, cls: CL_READ};
      for (int i = 0; i < 6; i++)
         for (int f = 0; f < 2; f++)
            if (op == opcode_of(sdlt_cls_t'(3'(i)), f[0]))
               d = '{ok: 1'b1, four: f[0], cls: sdlt_cls_t'(3'(i))};
      return d;
   endfunction : decode

   function automatic sdlt_cyc_t cycles(input logic [1:0] lc,
                                        input sdlt_cls_t c);
      sdlt_cyc_t y;
      y = '{mode: `SDLT_NONE, lat: `SDLT_NONE};
      case (c)
         CL_READ:
            if (lc != `SDLT_LC_50)
               y = '{mode: `SDLT_NOSUP, lat: `SDLT_NOSUP};
         CL_DIO:
         begin
            y.mode = `SDLT_MODE_DIO;
            if (lc == `SDLT_LC_90)
               y.lat = `SDLT_LAT_DIO_90;
            else if (lc == `SDLT_LC_104)
               y.lat = `SDLT_LAT_DIO_104;
         end
         CL_QIO:
         begin
            y.mode = `SDLT_MODE_QIO;
            if (lc == `SDLT_LC_50)
               y.lat = `SDLT_LAT_QIO_50;
            else if (lc == `SDLT_LC_104)
               y.lat = `SDLT_LAT_QIO_104;
            else
               y.lat = `SDLT_LAT_QIO_80;
         end
         default:
            if (lc != `SDLT_LC_50)
               y.lat = `SDLT_LAT_SLOW;
      endcase
      return y;
   endfunction : cycles

   function automatic logic [7:0] qry_byte(input logic [6:0] a);
      logic [6:0] off;
      logic [6:0] row;
      logic [6:0] col;
      logic [7:0] f;
      logic [1:0] lc;
      sdlt_cls_t  c;
      sdlt_cyc_t  y;
      off = a - `SDLT_Q_OFF_BODY;
      row = off / `SDLT_Q_ROWLEN;
      col = off % `SDLT_Q_ROWLEN;
      case (row)
         7'h00:   begin f = `SDLT_F50;  lc = `SDLT_LC_50;  end
         7'h01:   begin f = `SDLT_F80;  lc = `SDLT_LC_80;  end
         7'h02:   begin f = `SDLT_F90;  lc = `SDLT_LC_90;  end
         7'h03:   begin f = `SDLT_F104; lc = `SDLT_LC_104; end
         default: begin f = `SDLT_F133; lc = `SDLT_LC_104; end
      endcase
      c = sdlt_cls_t'(3'((col - 7'h02) >> 1));
      y = cycles(lc, c);
      // Top row keeps only the fast read
      if (row == `SDLT_Q_TOP_ROW && c != CL_FAST)
         y = '{mode: `SDLT_NOSUP, lat: `SDLT_NOSUP};
      case (a)
         `SDLT_Q_OFF_ID:   return `SDLT_Q_ID;
         `SDLT_Q_OFF_LEN:  return `SDLT_Q_LEN;
         `SDLT_Q_OFF_ROWS: return `SDLT_Q_ROWS;
         `SDLT_Q_OFF_RLEN: return {1'b0, `SDLT_Q_ROWLEN};
         `SDLT_Q_OFF_F:    return `SDLT_Q_ASC_F;
         default:          ;
      endcase
      if (a < `SDLT_Q_OFF_OPC)
         return `SDLT_Q_ASC_C;
      if (a < `SDLT_Q_OFF_BODY)
         return opcode_of(sdlt_cls_t'(3'((a - `SDLT_Q_OFF_OPC) >> 1)),
                          a[0]);
      if (a > `SDLT_Q_OFF_LAST)
         return 8'h00;
      if (col == 7'h00)
         return f;
      if (col == 7'h01)
         return {6'h00, lc};
      return col[0] ? y.lat : y.mode;
   endfunction : qry_byte

   // Pins pass two flops; edges found from the second and third
   always_ff @(posedge clock)
      if (!rstn)
      begin
         sck_p <= 3'h0;
         cs_p  <= 2'h3;
         io_p0 <= 4'h0;
         io_s  <= 4'h0;
         cs_d  <= 1'b1;
         flush_q <= 1'b0;
      end
      else
      begin
         sck_p <= {sck_p[1:0], sck};
         cs_p  <= {cs_p[0], cs_n};
         io_p0 <= io_in;
         io_s  <= io_p0;
         cs_d  <= cs_s;
         flush_q <= cs_s && !cs_d;
      end

   assign cs_s     = cs_p[1];
   assign sck_rise = sck_p[1] && !sck_p[2];
   assign sck_fall = !sck_p[1] && sck_p[2];
   assign next_opc = {opc[6:0], io_s[0]};
   assign dec      = decode(next_opc);
   assign cyc_new  = cycles(latency_code, dec.cls);
   assign accept   = dec.ok && cyc_new.mode != `SDLT_NOSUP;
   assign dum_tot  = cyc_q.mode[4:0] + cyc_q.lat[4:0];
   assign opc_done = st == ST_OPC && sck_rise && bit_cnt == 3'h7
                     && !cs_s;
   assign addr_done = st == ST_ADDR && sck_rise && addr_left == aw
                      && !cs_s;

   always_comb
   begin
      case (cls)
         CL_DIO:
         begin
            aw = 6'h02;
            next_addr = {addr[29:0], io_s[1:0]};
         end
         CL_QIO:
         begin
            aw = 6'h04;
            next_addr = {addr[27:0], io_s[3:0]};
         end
         default:
         begin
            aw = 6'h01;
            next_addr = {addr[30:0], io_s[0]};
         end
      endcase
      case (cls)
         CL_DOUT, CL_DIO: ow = 3'h2;
         CL_QOUT, CL_QIO: ow = 3'h4;
         default:         ow = 3'h1;
      endcase
   end

   // Command sequencer, one step per rising serial clock edge
   always_ff @(posedge clock)
      if (!rstn)
      begin
         st        <= ST_IDLE;
         opc       <= 8'h00;
         bit_cnt   <= 3'h0;
         cls       <= CL_READ;
         four      <= 1'b0;
         lc_q      <= 2'h0;
         cyc_q     <= '{mode: `SDLT_NONE, lat: `SDLT_NONE};
         addr      <= 32'h0;
         addr_left <= 6'h00;
         dum_cnt   <= 5'h00;
      end
      else if (cs_s)
         st <= ST_IDLE;
      else if (sck_rise)
         case (st)
            ST_IDLE:
            begin
               opc     <= {7'h00, io_s[0]};
               bit_cnt <= 3'h1;
               st      <= ST_OPC;
            end
            ST_OPC:
            begin
               opc     <= next_opc;
               bit_cnt <= bit_cnt + 3'h1;
               if (bit_cnt == 3'h7)
               begin
                  cls       <= dec.cls;
                  four      <= dec.four;
                  lc_q      <= latency_code;
                  cyc_q     <= cyc_new;
                  addr      <= 32'h0;
                  addr_left <= dec.four ? `SDLT_ADDR4 : `SDLT_ADDR3;
                  st        <= accept ? ST_ADDR : ST_IGN;
               end
            end
            ST_ADDR:
            begin
               addr      <= next_addr;
               addr_left <= addr_left - aw;
               if (addr_left == aw)
               begin
                  dum_cnt <= dum_tot;
                  st      <= dum_tot == 5'h00 ? ST_DATA : ST_DUMMY;
               end
            end
            ST_DUMMY:
            begin
               // Mode bits are clocked through but not acted on
               dum_cnt <= dum_cnt - 5'h01;
               if (dum_cnt == 5'h01)
                  st <= ST_DATA;
            end
            default:
               st <= st;
         endcase

   always_ff @(posedge clock)
      if (!rstn)
      begin
         rd_start   <= 1'b0;
         rd_addr    <= 32'h0;
         rd_cls     <= CL_READ;
         rd_four    <= 1'b0;
         cmd_reject <= 1'b0;
      end
      else
      begin
         rd_start   <= addr_done;
         cmd_reject <= opc_done && !accept;
         if (addr_done)
         begin
            rd_addr <= next_addr;
            rd_cls  <= cls;
            rd_four <= four;
         end
      end

   // An empty buffer cannot stall the host, so zeros go out
   assign need = st == ST_DATA && sck_fall && bl == 4'h0;
   assign drain.ready = need;
   assign cur = (bl != 4'h0) ? sh : (drain.valid ? drain.data : 8'h00);

   always_comb
      case (ow)
         3'h4:    next_io = cur[7:4];
         3'h2:    next_io = {2'h0, cur[7:6]};
         default: next_io = {2'h0, cur[7], 1'b0};
      endcase

   always_ff @(posedge clock)
      if (!rstn)
      begin
         io_out   <= 4'h0;
         io_oe    <= 4'h0;
         sh       <= 8'h00;
         bl       <= 4'h0;
         underrun <= 1'b0;
      end
      else if (cs_s)
      begin
         io_oe    <= 4'h0;
         bl       <= 4'h0;
         underrun <= 1'b0;
      end
      else
      begin
         underrun <= need && !drain.valid;
         if (st == ST_DATA && sck_fall)
         begin
            io_out <= next_io;
            io_oe  <= ow == 3'h4 ? 4'hF : (ow == 3'h2 ? 4'h3 : 4'h2);
            sh     <= cur << ow;
            bl     <= (bl == 4'h0 ? 4'h8 : bl) - {1'b0, ow};
         end
      end

   always_ff @(posedge clock)
      if (!rstn)
         qry_data <= 8'h00;
      else
         qry_data <= qry_byte(qry_addr);

   sdlt_buf #(.W(8), .DEPTH(BUF_DEPTH)) u_buf (
      .clock    (clock),
      .rstn     (rstn),
      .flush    (flush_q),
      .in_valid (in_valid),
      .in_data  (in_data),
      .in_ready (in_ready),
      .out      (drain.src)
   );

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   sequence s_opc(logic [7:0] op);
      opc_done ##0 next_opc == op;
   endsequence
   sequence s_addr(sdlt_cls_t c, logic [1:0] lc);
      addr_done ##0 (cls == c && lc_q == lc);
   endsequence

   AST_QRY_ID: assert property (
      rstn && qry_addr == `SDLT_Q_OFF_ID |=> qry_data == `SDLT_Q_ID)
      else $error("query id byte wrong");
   AST_QRY_LEN: assert property (
      qry_addr == `SDLT_Q_OFF_LEN |=> qry_data == `SDLT_Q_LEN)
      else $error("query length byte wrong");
   AST_QRY_HDR: assert property (
      qry_addr == `SDLT_Q_OFF_F |=> qry_data == `SDLT_Q_ASC_F)
      else $error("query header byte wrong");
   AST_QRY_ROW4: assert property (
      qry_addr == `SDLT_Q_OFF_ROW4 |=> qry_data == `SDLT_F90)
      else $error("row frequency byte wrong");
   AST_READ4_DEC: assert property (
      s_opc(`SDLT_OPC_RD4) ##0 latency_code == `SDLT_LC_50
      |=> st == ST_ADDR && cls == CL_READ && four)
      else $error("four-byte normal read not decoded");
   AST_FAST3_DEC: assert property (
      s_opc(`SDLT_OPC_FST3) |=> st == ST_ADDR && cls == CL_FAST && !four)
      else $error("fast read not decoded");
   AST_QIO4_DEC: assert property (
      s_opc(`SDLT_OPC_QIO4) |=> st == ST_ADDR && cls == CL_QIO && four)
      else $error("quad io read not decoded");
   AST_READ_REJECT: assert property (
      s_opc(`SDLT_OPC_RD3) ##0 latency_code != `SDLT_LC_50
      |=> (st == ST_IGN) and (!cs_s [*2] |-> st == ST_IGN))
      else $error("normal read taken above its limit");
   AST_FAST_C3: assert property (
      s_addr(CL_FAST, `SDLT_LC_50) |=> st == ST_DATA)
      else $error("fast read at low code has latency");
   AST_DIO_C3: assert property (
      s_addr(CL_DIO, `SDLT_LC_50) |=> st == ST_DUMMY && dum_cnt == 5'h04)
      else $error("dual io count wrong");
   AST_QIO_C3: assert property (
      s_addr(CL_QIO, `SDLT_LC_50) |=> st == ST_DUMMY && dum_cnt == 5'h03)
      else $error("quad io count wrong at 11b");
   AST_FAST_C0: assert property (
      s_addr(CL_FAST, `SDLT_LC_80) |=> dum_cnt == 5'h08)
      else $error("fast read latency wrong at 00b");
   AST_QIO_C0: assert property (
      s_addr(CL_QIO, `SDLT_LC_80) |=> dum_cnt == 5'h06)
      else $error("quad io count wrong at 00b");
   AST_DOUT_C1: assert property (
      s_addr(CL_DOUT, `SDLT_LC_90) |=> dum_cnt == 5'h08)
      else $error("dual out latency wrong at 01b");
   AST_QIO_C2: assert property (
      s_addr(CL_QIO, `SDLT_LC_104) |=> dum_cnt == 5'h07)
      else $error("quad io count wrong at 10b");
   AST_OE_DATA: assert property (
      st != ST_DATA |-> io_oe == 4'h0)
      else $error("pins driven outside data phase");
endmodule : sdlt_top

// *** bench/sdlt_host.sv ***
// Host controller model issuing read frames on the serial link
`timescale 1ns/10ps
module sdlt_host (
   input  wire logic       clock,
   input  wire logic [3:0] pin,
   output logic            sck,
   output logic            cs_n,
   output logic      [3:0] drv
);
   initial
   begin
      sck  = 1'b0;
      cs_n = 1'b1;
      drv  = 4'hA;
   end

   // One serial period of 8 clocks; pins sampled late in the low half
   task automatic cyc(input logic [3:0] v, output logic [3:0] s);
      @(posedge clock);
      sck <= 1'b0;
      drv <= v;
      repeat (4) @(posedge clock);
      s = pin;
      sck <= 1'b1;
      repeat (3) @(posedge clock);
   endtask : cyc

   task automatic frame(input logic [7:0] opc, input logic [31:0] addr,
      input int ab, input int aw, input int dum, input int ow,
      input int nb, output logic [15:0] got);
      logic [3:0]  s;
      logic [3:0]  v;
      logic [31:0] sh;
      int          i;
      sh = addr << (32 - ab);
      got = 16'h0000;
      @(posedge clock);
      cs_n <= 1'b0;
      repeat (4) @(posedge clock);
      for (i = 7; i >= 0; i--)
         cyc({{3{~opc[i]}}, opc[i]}, s);
      for (i = 0; i < ab / aw; i++)
      begin
         v = (aw == 4) ? sh[31:28] : (aw == 2) ? {~sh[31:30], sh[31:30]}
            : {{3{~sh[31]}}, sh[31]};
         cyc(v, s);
         sh = sh << aw;
      end
      // Unused lanes toggle so a stale level is never mistaken for data
      repeat (dum) cyc(~drv, s);
      for (i = 0; i < nb * 8 / ow; i++)
      begin
         cyc(~drv, s);
         got = (ow == 4) ? {got[11:0], s} : (ow == 2) ?
            {got[13:0], s[1:0]} : {got[14:0], s[1]};
      end
      @(posedge clock);
      sck <= 1'b0;
      repeat (4) @(posedge clock);
      cs_n <= 1'b1;
      drv  <= ~drv;
      repeat (12) @(posedge clock);
   endtask : frame
endmodule : sdlt_host

// *** bench/tb_top.sv ***
// Self-checking bench for the serial read latency table block
`timescale 1ns/10ps
module tb_top;
   localparam logic [375:0] QRY = {8'h90, 8'h56, 8'h06, 8'h0E, 8'h46,
      8'h43, 8'h03, 8'h13, 8'h0B, 8'h0C, 8'h3B, 8'h3C, 8'h6B, 8'h6C,
      8'hBB, 8'hBC, 8'hEB, 8'hEC, 8'h32, 8'h03, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h02, 8'h01,
      8'h50, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h08, 8'h00, 8'h08, 8'h00,
      8'h08, 8'h04, 8'h00, 8'h02, 8'h04, 8'h5A};
   // Opcode, code, class, four-byte, reject
   localparam logic [407:0] DEC = {24'h033000, 24'h133010, 24'h0B3100,
      24'h0C3110, 24'h3B3200, 24'h3C3210, 24'h6B3300, 24'h6C3310,
      24'hBB3400, 24'hBC3410, 24'hEB3500, 24'hEC3510, 24'h030001,
      24'h131011, 24'h032001, 24'hA53001, 24'h0B0100};
   // Opcode, code, dummies, lanes, enables, byte
   localparam logic [223:0] DAT = {32'hEB064F5A, 32'hEB334F96,
      32'h3B0823C3, 32'h3C18233C, 32'hEB274F69, 32'hBB3423A6,
      32'h6B304FE1};
   logic        clock;
   logic        rstn;
   logic        sck;
   logic        cs_n;
   logic [3:0]  drv;
   logic [3:0]  io_out;
   logic [3:0]  io_oe;
   wire  [3:0]  pin;
   logic [1:0]  latency_code;
   logic        rd_start;
   logic [31:0] rd_addr;
   logic [2:0]  rd_cls;
   logic        rd_four;
   logic        cmd_reject;
   logic        in_valid;
   logic [7:0]  in_data;
   logic        in_ready;
   logic        underrun;
   logic [6:0]  qry_addr;
   logic [7:0]  qry_data;
   logic [2:0]  s_cls;
   logic        s_four;
   logic [31:0] s_addr;
   logic [3:0]  s_oe;
   logic [15:0] got;
   logic [23:0] row;
   logic [31:0] dr;
   int          n_errors;
   int          num_checks;
   int          n_start;
   int          n_rej;
   int          n_und;
   int          i;
   int          st;
   int          rj;

   assign pin = (io_oe & io_out) | (~io_oe & drv);

   sdlt_top sdlt_top_inst (.clock(clock), .rstn(rstn), .sck(sck),
      .cs_n(cs_n), .io_in(pin), .io_out(io_out), .io_oe(io_oe),
      .latency_code(latency_code), .rd_start(rd_start),
      .rd_addr(rd_addr), .rd_cls(rd_cls), .rd_four(rd_four),
      .cmd_reject(cmd_reject), .in_valid(in_valid), .in_data(in_data),
      .in_ready(in_ready), .underrun(underrun), .qry_addr(qry_addr),
      .qry_data(qry_data));

   sdlt_host sdlt_host_inst (.clock(clock), .pin(pin), .sck(sck),
      .cs_n(cs_n), .drv(drv));

   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   always @(posedge clock)
   begin
      if (rd_start === 1'b1)
      begin
         n_start++;
         s_cls = rd_cls;
         s_four = rd_four;
         s_addr = rd_addr;
      end
      if (cmd_reject === 1'b1)
         n_rej++;
      if (underrun === 1'b1)
         n_und++;
      if (io_oe !== 4'h0)
         s_oe = io_oe;
   end

   function automatic int aw_of(input logic [7:0] opc);
      return (opc[7:4] == 4'hB) ? 2 : (opc[7:4] == 4'hE) ? 4 : 1;
   endfunction : aw_of

   task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] seen);
      num_checks++;
      if (exp !== seen)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish

   initial
   begin
      repeat (60000) @(posedge clock);
      n_errors++;
      $display("watchdog expired");
      tally_and_finish;
   end

   initial
   begin
      rstn = 1'b0;
      latency_code = 2'h3;
      in_valid = 1'b0;
      in_data = 8'h00;
      qry_addr = 7'h00;
      s_oe = 4'h0;
      repeat (8) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      #1;
      check("io_oe after reset", 32'h0, {28'h0, io_oe});
      check("in_ready after reset", 32'h1, {31'h0, in_ready});
      $display("test reset done");
      for (i = 0; i < 48; i++)
      begin
         @(posedge clock);
         qry_addr <= (i < 47) ? 7'(i) : 7'h58;
         repeat (2) @(posedge clock);
         #1;
         check("qry_data", (i < 47) ? QRY[(46 - i) * 8 +: 8] : 8'h00,
            {24'h0, qry_data});
      end
      $display("test query done");
      for (i = 0; i < 17; i++)
      begin
         row = DEC[(16 - i) * 24 +: 24];
         st = n_start;
         rj = n_rej;
         s_oe = 4'h0;
         @(posedge clock);
         latency_code <= row[13:12];
         sdlt_host_inst.frame(row[23:16], 32'hC35A9617, row[4] ? 32 : 24,
            aw_of(row[23:16]), 0, 1, 0, got);
         if (row[0])
         begin
            check("reject count", rj + 1, n_rej);
            check("io_oe on reject", 32'h0, {28'h0, s_oe});
         end
         else
         begin
            check("rd_cls", row[10:8], s_cls);
            check("rd_four", row[4], s_four);
            check("rd_addr", row[4] ? 32'hC35A9617 : 32'h005A9617,
               s_addr);
            check("start count", st + 1, n_start);
         end
      end
      $display("test decode done");
      @(posedge clock);
      latency_code <= 2'h3;
      in_valid <= 1'b1;
      in_data <= 8'hA5;
      @(posedge clock);
      in_data <= 8'h3C;
      @(posedge clock);
      in_valid <= 1'b0;
      @(posedge clock);
      #1;
      check("in_ready when full", 32'h0, {31'h0, in_ready});
      sdlt_host_inst.frame(8'h0B, 32'h00123456, 24, 1, 0, 1, 2, got);
      check("fast read data", 32'hA53C, got);
      st = n_und;
      sdlt_host_inst.frame(8'h0B, 32'h00123456, 24, 1, 0, 1, 1, got);
      // Closing low-going clock asks for a second byte
      check("underrun count", st + 2, n_und);
      check("underrun data", 32'h0, got);
      $display("test buffer done");
      for (i = 0; i < 7; i++)
      begin
         dr = DAT[(6 - i) * 32 +: 32];
         s_oe = 4'h0;
         @(posedge clock);
         latency_code <= dr[21:20];
         in_valid <= 1'b1;
         in_data <= dr[7:0];
         @(posedge clock);
         in_valid <= 1'b0;
         sdlt_host_inst.frame(dr[31:24], 32'h00A1B2C3,
            (dr[31:24] == 8'h3C) ? 32 : 24, aw_of(dr[31:24]),
            dr[19:16], dr[15:12], 1, got);
         check("read data", dr[7:0], got);
         check("io_oe", dr[11:8], s_oe);
      end
      $display("test latency done");
      tally_and_finish;
   end
endmodule : tb_top
